// File: core/sblp_pkg.sv
// constants, register map and state types of the serial boot loader port
// assumes a 20 MHz core clock and a 32-bit AHB-Lite register bus
package sblp_pkg;

    // timing
    localparam int unsigned CORE_PERIOD_NS    = 50;
    localparam int unsigned SCLK_PERIOD_NS    = 400;
    localparam int unsigned SCLK_HALF_CYC_INT = (SCLK_PERIOD_NS + 2 * CORE_PERIOD_NS - 1) / (2 * CORE_PERIOD_NS);
    localparam logic [2:0]  SCLK_HALF_LAST    = 3'(SCLK_HALF_CYC_INT - 1);
    localparam logic [2:0]  SCLK_SAMPLE_AT    = 3'h2;
    localparam logic [4:0]  CFG_SETTLE        = 5'h03;

    // boot transfer sizes
    localparam int unsigned KERNEL_INSTR_INT  = 256;
    localparam logic [8:0]  BOOT_DMA_WORDS    = 9'(KERNEL_INSTR_INT * 48 / 32);
    localparam logic [4:0]  WORD_LAST_BIT     = 5'h1F;
    localparam logic [31:0] READ_CMD_WORD     = 32'h000000C0;

    // boot configuration pin patterns
    localparam logic [2:0]  BOOT_SPI_SLAVE    = 3'h0;
    localparam logic [2:0]  BOOT_SPI_MASTER   = 3'h1;
    localparam logic [2:0]  BOOT_LINK0        = 3'h4;

    // register byte offsets
    localparam logic [7:0]  CTRL_OFS          = 8'h00;
    localparam logic [7:0]  STAT_OFS          = 8'h04;
    localparam logic [7:0]  RXBUF_OFS         = 8'h08;

    // control register fields
    localparam int          CTRL_EN_BIT       = 0;
    localparam int          CTRL_MS_BIT       = 1;
    localparam int          CTRL_HIGH_BIT_FIRST_SELECT_BIT     = 2;
    localparam int          CTRL_WL_LO        = 3;
    localparam int          CTRL_WL_HI        = 4;
    localparam int          CTRL_SLAVE_OUTPUT_DISABLE_BIT    = 5;
    localparam int          CTRL_SEND_ZERO_OR_LAST_SELECT_BIT    = 6;
    localparam int          CTRL_RCV_BIT      = 7;
    localparam int          CTRL_CLOCK_POLARITY_BIT_BIT    = 8;
    localparam int          CTRL_CLOCK_PHASE_BIT_BIT   = 9;
    localparam logic        CTRL_HIGH_BIT_FIRST_SELECT_RST     = 1'b0;
    localparam logic [1:0]  CTRL_WL_RST       = 2'h2;

    // status register fields
    localparam int          STAT_MODE_LO      = 0;
    localparam int          STAT_BUSY_BIT     = 3;
    localparam int          STAT_DONE_BIT     = 4;
    localparam int          STAT_ERR_BIT      = 5;
    localparam int          STAT_LINK_BIT     = 6;
    localparam int          STAT_CNT_LO       = 16;

    typedef enum logic [3:0] {
        ST_CFG,
        ST_SL_WAITHI,
        ST_SL_WAITLO,
        ST_SL_RX,
        ST_MS_RUN,
        ST_DONE,
        ST_LINK,
        ST_ERR,
        ST_IDLE
    } sblp_fsm_t;

    typedef struct packed {
        sblp_fsm_t   state;
        logic [2:0]  mode;
        logic [31:0] shreg;
        logic [31:0] txreg;
        logic [4:0]  bitcnt;
        logic [8:0]  dma_cnt;
        logic [8:0]  dma_addr;
        logic        discard;
        logic        begun;
        logic        sclk_prev;
        logic        sclk_o;
        logic        sclk_oe_n;
        logic [2:0]  hcnt;
        logic        flag_n;
        logic        mosi_o;
        logic        mosi_oe_n;
        logic        miso_o;
        logic        miso_oe_n;
        logic        mem_we;
        logic [8:0]  mem_addr;
        logic [31:0] mem_wdata;
        logic [31:0] rx_buf;
        logic        run;
        logic [23:0] pc;
        logic        link;
        logic        err;
        logic        high_bit_first_select;
        logic [1:0]  wl;
        logic        a_wr;
        logic [7:0]  a_addr;
        logic [31:0] hrdata;
        logic        hready;
        logic        hresp;
    } sblp_state_t;

    localparam sblp_state_t STATE_RST = '{
        state     : ST_CFG,
        sclk_prev : 1'b1,
        sclk_o    : 1'b1,
        sclk_oe_n : 1'b1,
        flag_n    : 1'b1,
        mosi_oe_n : 1'b1,
        miso_oe_n : 1'b1,
        high_bit_first_select      : CTRL_HIGH_BIT_FIRST_SELECT_RST,
        wl        : CTRL_WL_RST,
        hready    : 1'b1,
        default   : '0
    };

endpackage

// File: core/sblp_sync2.sv
// two-flop synchroniser for a group of levels
// assumes the inputs are unrelated to the clock; reset forces RST_VAL
`timescale 1ns/1ps
module sblp_sync2 #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= RST_VAL;
            q_o    <= RST_VAL;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule // sblp_sync2

// File: core/sblp_boot_port.sv
// serial boot loader port: loads the boot kernel over the serial port after reset
// assumes boot pins static around reset; kernel memory sits behind the MEM_* write port
// How it works
// - kernel load is one 384-word DMA
// - receive word size always 32 bits
// - narrow data packed into words LSB first
// - select held low, bits without gaps
// - slave DMA preloaded with 384 words
// - slave boot defaults in control register
// - clock idles high, toggles at bit start
// - master boot: drive clock, flag select low
// - master sends read 0x03, zero address
// - opcode shifted LSB first, one word
// - first boot bit sampled on cycle 32
// - first received word discarded by hardware in master boot only
// - master boot same for any slave
// - bit order resets to LSB first
// - patterns 000 slave, 001 master boot
`timescale 1ns/1ps
module sblp_boot_port
    import sblp_pkg::*;
#(
    parameter logic [23:0] KERNEL_ENTRY = 24'h000004
) (
    // clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_N_I,
    // boot configuration pins
    input  wire logic [2:0]  BOOT_CFG_I,
    // serial pins
    input  wire logic        SCLK_I,
    output logic             SCLK_O,
    output logic             SCLK_OE_N_O,
    input  wire logic        MOSI_I,
    output logic             MOSI_O,
    output logic             MOSI_OE_N_O,
    input  wire logic        MISO_I,
    output logic             MISO_O,
    output logic             MISO_OE_N_O,
    input  wire logic        DEVSEL_N_I,
    output logic             FLAG_SEL_N_O,
    // kernel memory write port
    output logic             MEM_WE_O,
    output logic [8:0]       MEM_ADDR_O,
    output logic [31:0]      MEM_WDATA_O,
    // core start
    output logic             KERNEL_RUN_O,
    output logic [23:0]      KERNEL_PC_O,
    output logic             LINK_BOOT_O,
    // AHB-Lite slave
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic [31:0]      HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O
);

    sblp_state_t s;
    sblp_state_t n;
    logic        rst_n;
    logic [2:0]  cfg_s;
    logic [3:0]  pins_s;
    logic        devsel_s;
    logic        sclk_s;
    logic        mosi_s;
    logic        miso_s;
    logic        got_bit;
    logic        bit_val;
    logic        rx_rise;
    logic [31:0] shifted;

    // reset release and pin synchronisers
    sblp_sync2 #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RESET_N_I),
        .d_i     (1'b1),
        .q_o     (rst_n)
    );

    // boot pins are caught after release, once the synchroniser has settled
    sblp_sync2 #(.W(3), .RST_VAL(3'h0)) u_cfg_sync (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (rst_n),
        .d_i     (BOOT_CFG_I),
        .q_o     (cfg_s)
    );

    // clock and data share one latency, so sampled data stays aligned to edges
    sblp_sync2 #(.W(4), .RST_VAL(4'hC)) u_pin_sync (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (rst_n),
        .d_i     ({DEVSEL_N_I, SCLK_I, MOSI_I, MISO_I}),
        .q_o     (pins_s)
    );

    assign devsel_s = pins_s[3];
    assign sclk_s   = pins_s[2];
    assign mosi_s   = pins_s[1];
    assign miso_s   = pins_s[0];

    // word packing follows the bit-order control
    function automatic logic [31:0] shift_in(input logic [31:0] r, input logic b, input logic hi_first);
        return hi_first ? {r[30:0], b} : {b, r[31:1]};
    endfunction

    // upper address bits are not decoded, the map aliases every 256 bytes
    function automatic logic [31:0] rd_word(input logic [7:0] a, input sblp_state_t t);
        logic [31:0] w;
        w = 32'h00000000;
        case (a)
            CTRL_OFS:
            begin
                w[CTRL_EN_BIT]                = 1'b1;
                w[CTRL_MS_BIT]                = (t.mode == BOOT_SPI_MASTER);
                w[CTRL_HIGH_BIT_FIRST_SELECT_BIT]              = t.high_bit_first_select;
                w[CTRL_WL_HI:CTRL_WL_LO]      = t.wl;
                w[CTRL_SLAVE_OUTPUT_DISABLE_BIT]             = t.miso_oe_n;
                w[CTRL_SEND_ZERO_OR_LAST_SELECT_BIT]             = 1'b0;
                w[CTRL_RCV_BIT]               = 1'b1;
                w[CTRL_CLOCK_POLARITY_BIT_BIT]             = 1'b1;
                w[CTRL_CLOCK_PHASE_BIT_BIT]            = 1'b1;
            end
            STAT_OFS:
            begin
                w[STAT_MODE_LO +: 3]          = t.mode;
                w[STAT_BUSY_BIT]              = (t.state == ST_SL_RX) || (t.state == ST_MS_RUN);
                w[STAT_DONE_BIT]              = t.run;
                w[STAT_ERR_BIT]               = t.err;
                w[STAT_LINK_BIT]              = t.link;
                w[STAT_CNT_LO +: 9]           = t.dma_cnt;
            end
            RXBUF_OFS:
            begin
                w = t.rx_buf;
            end
            default:
            begin
                w = 32'h00000000;
            end
        endcase
        return w;
    endfunction

    always_comb
    begin
        n       = s;
        got_bit = 1'b0;
        bit_val = 1'b0;
        rx_rise = sclk_s & ~s.sclk_prev;
        n.mem_we    = 1'b0;
        n.sclk_prev = sclk_s;

        // data phase of a write; the word length field is kept but never shortens a word
        if (s.a_wr && (s.a_addr == CTRL_OFS))
        begin
            n.high_bit_first_select = HWDATA_I[CTRL_HIGH_BIT_FIRST_SELECT_BIT];
            n.wl   = HWDATA_I[CTRL_WL_HI:CTRL_WL_LO];
        end
        n.a_wr   = HSEL_I & HTRANS_I[1] & HREADY_I & HWRITE_I;
        n.a_addr = HADDR_I[7:0];

        case (s.state)
            ST_CFG:
            begin
                n.bitcnt = s.bitcnt + 5'h01;
                if (s.bitcnt == CFG_SETTLE)
                begin
                    n.bitcnt   = 5'h00;
                    n.mode     = cfg_s;
                    n.dma_cnt  = BOOT_DMA_WORDS;
                    n.dma_addr = 9'h000;
                    case (cfg_s)
                        BOOT_SPI_SLAVE:
                        begin
                            n.state = ST_SL_WAITHI;
                        end
                        BOOT_SPI_MASTER:
                        begin
                            n.state     = ST_MS_RUN;
                            n.flag_n    = 1'b0;
                            n.sclk_oe_n = 1'b0;
                            n.mosi_oe_n = 1'b0;
                            n.sclk_o    = 1'b1;
                            n.hcnt      = 3'h0;
                            n.txreg     = READ_CMD_WORD;
                            n.discard   = 1'b1;
                        end
                        BOOT_LINK0:
                        begin
                            n.state = ST_LINK;
                            n.link  = 1'b1;
                        end
                        default:
                        begin
                            n.state = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_SL_WAITHI:
            begin
                // a select tied low never produces the edge, so boot waits here
                if (devsel_s)
                begin
                    n.state = ST_SL_WAITLO;
                end
            end
            ST_SL_WAITLO:
            begin
                if (!devsel_s)
                begin
                    n.state  = ST_SL_RX;
                    n.bitcnt = 5'h00;
                end
            end
            ST_SL_RX:
            begin
                if (devsel_s)
                begin
                    n.state = ST_ERR;
                    n.err   = 1'b1;
                end
                else if (rx_rise)
                begin
                    got_bit = 1'b1;
                    bit_val = mosi_s;
                end
            end
            ST_MS_RUN:
            begin
                // no address width or device type is assumed past the fixed command word
                n.hcnt = s.hcnt + 3'h1;
                if (s.hcnt == SCLK_HALF_LAST)
                begin
                    n.hcnt   = 3'h0;
                    n.sclk_o = ~s.sclk_o;
                    if (s.sclk_o)
                    begin
                        n.begun  = 1'b1;
                        n.mosi_o = s.high_bit_first_select ? s.txreg[31] : s.txreg[0];
                        n.txreg  = s.high_bit_first_select ? {s.txreg[30:0], 1'b0} : {1'b0, s.txreg[31:1]};
                    end
                end
                else if (s.sclk_o && s.begun && (s.hcnt == SCLK_SAMPLE_AT))
                begin
                    got_bit = 1'b1;
                    bit_val = miso_s;
                end
            end
            ST_DONE, ST_LINK, ST_ERR, ST_IDLE:
            begin
                n.state = s.state;
            end
            default:
            begin
                n.state = ST_IDLE;
            end
        endcase

        shifted = shift_in(s.shreg, bit_val, s.high_bit_first_select);
        if (got_bit)
        begin
            n.shreg  = shifted;
            n.bitcnt = s.bitcnt + 5'h01;
            if (s.bitcnt == WORD_LAST_BIT)
            begin
                if (s.discard)
                begin
                    n.discard = 1'b0;
                end
                else
                begin
                    n.mem_we    = 1'b1;
                    n.mem_addr  = s.dma_addr;
                    n.mem_wdata = shifted;
                    n.rx_buf    = shifted;
                    n.dma_addr  = s.dma_addr + 9'h001;
                    n.dma_cnt   = s.dma_cnt - 9'h001;
                    if (s.dma_cnt == 9'h001)
                    begin
                        n.state     = ST_DONE;
                        n.run       = 1'b1;
                        n.pc        = KERNEL_ENTRY;
                        n.flag_n    = 1'b1;
                        n.sclk_o    = 1'b1;
                        n.sclk_oe_n = 1'b1;
                        n.mosi_oe_n = 1'b1;
                    end
                end
            end
        end

        // read data is formed from the next state so a write just before is seen
        if (HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I)
        begin
            n.hrdata = rd_word(HADDR_I[7:0], n);
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= STATE_RST;
        end
        else
        begin
            s <= n;
        end
    end

    assign SCLK_O       = s.sclk_o;
    assign SCLK_OE_N_O  = s.sclk_oe_n;
    assign MOSI_O       = s.mosi_o;
    assign MOSI_OE_N_O  = s.mosi_oe_n;
    assign MISO_O       = s.miso_o;
    assign MISO_OE_N_O  = s.miso_oe_n;
    assign FLAG_SEL_N_O = s.flag_n;
    assign MEM_WE_O     = s.mem_we;
    assign MEM_ADDR_O   = s.mem_addr;
    assign MEM_WDATA_O  = s.mem_wdata;
    assign KERNEL_RUN_O = s.run;
    assign KERNEL_PC_O  = s.pc;
    assign LINK_BOOT_O  = s.link;
    assign HRDATA_O     = s.hrdata;
    assign HREADYOUT_O  = s.hready;
    assign HRESP_O      = s.hresp;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!rst_n);

    sequence ms_launch;
        (s.state == ST_CFG) ##1 (s.state == ST_MS_RUN);
    endsequence

    sequence cfg_pick(logic [2:0] pat);
        (s.state == ST_CFG) && (s.bitcnt == CFG_SETTLE) && (cfg_s == pat);
    endsequence

    kernel_count_a: assert property ($rose(s.run) |-> (s.dma_addr == BOOT_DMA_WORDS) && (s.dma_cnt == 9'h000))
        else $error("kernel load did not move 384 words");
    word_size_a: assert property (s.mem_we |-> ($past(s.bitcnt) == WORD_LAST_BIT) && (s.bitcnt == 5'h00))
        else $error("word written before 32 bits");
    lsb_pack_a: assert property ((s.mem_we && !$past(s.high_bit_first_select)) |-> s.mem_wdata[31] == $past(bit_val))
        else $error("last received bit not at word top");
    select_gap_a: assert property ((s.state == ST_SL_RX) && devsel_s |=> (s.state == ST_ERR) && s.err)
        else $error("select release during boot not flagged");
    dma_preload_a: assert property ((s.state == ST_SL_WAITLO) && !devsel_s |=> (s.state == ST_SL_RX)
        && (s.dma_cnt == BOOT_DMA_WORDS))
        else $error("slave dma count not preloaded");
    slave_miso_a: assert property ((s.mode == BOOT_SPI_SLAVE) |-> MISO_OE_N_O)
        else $error("data output driven in slave boot");
    sclk_idle_a: assert property ($fell(SCLK_O) |-> (s.state == ST_MS_RUN) && ($past(s.hcnt) == SCLK_HALF_LAST))
        else $error("serial clock toggled off its half period");
    cmd_word_a: assert property (ms_launch |-> (s.txreg == READ_CMD_WORD) && s.discard && !FLAG_SEL_N_O)
        else $error("master boot did not load read command");
    discard_a: assert property ($fell(s.discard) |-> !s.mem_we && (s.rx_buf == $past(s.rx_buf)))
        else $error("command-time word reached memory");
    mode_sel_a: assert property (cfg_pick(BOOT_SPI_SLAVE) |=> (s.state == ST_SL_WAITHI) ##1 FLAG_SEL_N_O)
        else $error("pattern 000 did not select slave boot");
    link_sel_a: assert property (cfg_pick(BOOT_LINK0) |=> LINK_BOOT_O && (s.state == ST_LINK))
        else $error("pattern 100 did not select link boot");
    run_start_a: assert property ($rose(KERNEL_RUN_O) |-> (KERNEL_PC_O == KERNEL_ENTRY) ##1 (!MEM_WE_O)[*4])
        else $error("kernel start or transfer stop wrong");
    flag_hold_a: assert property ($rose(FLAG_SEL_N_O) |-> s.run && (s.state == ST_DONE))
        else $error("flag select released before kernel loaded");

endmodule // sblp_boot_port

// File: verif/sblp_far_end.sv
// far-side serial party: host in slave boot, flash-like slave in master boot
// assumes pin levels already resolved; its link clock runs only inside a frame
`timescale 1ns/1ps
module sblp_far_end (
    // from the port
    input  wire logic   sclk_w_i,
    input  wire logic   flag_n_i,
    input  wire logic   mosi_w_i,
    // to the port
    output logic        sclk_o,
    output logic        mosi_o,
    output logic        devsel_n_o,
    output logic        miso_o,
    output logic [31:0] cmd_o
);
    int          bitn = 0;
    logic [31:0] sh;

    function automatic logic [31:0] word(input int k);
        return {16'(k) ^ 16'hA5C3, ~16'(k)};
    endfunction

    initial
    begin
        sclk_o     = 1'b1;
        mosi_o     = 1'b0;
        devsel_n_o = 1'b1;
        miso_o     = 1'b1;
        cmd_o      = '0;
    end

    // ends by raising select while the port still expects words
    task automatic slave_send(input int n);
        logic [31:0] w;
        #7 devsel_n_o = 1'b0;
        #800;
        for (int k = 0; k < n; k++)
        begin
            w = word(k);
            for (int b = 0; b < 32; b++)
            begin
                sclk_o = 1'b0;
                mosi_o = w[b];
                #200 sclk_o = 1'b1;
                #200;
            end
        end
        devsel_n_o = 1'b1;
        mosi_o     = ~mosi_o;
    endtask

    // junk in the first word makes a missed discard visible
    always @(negedge sclk_w_i)
        if (flag_n_i === 1'b0)
        begin
            sh = (bitn < 32) ? 32'hA5000000 : word(bitn / 32 - 1);
            miso_o <= sh[bitn % 32];
            bitn++;
        end

    always @(posedge sclk_w_i)
        if (flag_n_i === 1'b0 && bitn > 0 && bitn <= 32)
            cmd_o[bitn - 1] <= mosi_w_i;

    always @(posedge flag_n_i)
        miso_o <= ~miso_o;
endmodule // sblp_far_end

// File: verif/sblp_boot_port_tb.sv
// self-checking bench of the serial boot loader port
// assumes the far-side model sblp_far_end and a 20 MHz core clock
`timescale 1ns/1ps
module sblp_boot_port_tb;
    import sblp_pkg::*;
    logic        clk, rst_n, hsel, hwrite, hready, hresp, f_sclk, f_mosi, f_miso, devsel_n;
    logic        sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, flag_n, mem_we, run, link;
    logic        sclk_w, mosi_w, miso_w;
    logic [2:0]  cfg;
    logic [1:0]  htrans;
    logic [8:0]  mem_addr;
    logic [23:0] pc;
    logic [31:0] haddr, hwdata, hrdata, mem_wdata, rd, cmd;
    int          err_count = 0;
    int          checked = 0;
    int          nw = 0;

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    assign sclk_w = (sclk_oe_n === 1'b0) ? sclk_o : f_sclk;
    assign mosi_w = (mosi_oe_n === 1'b0) ? mosi_o : f_mosi;
    assign miso_w = (miso_oe_n === 1'b0) ? miso_o : f_miso;

    sblp_boot_port #(.KERNEL_ENTRY(24'h000123)) u_sblp_boot_port (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .BOOT_CFG_I(cfg),
        .SCLK_I(sclk_w), .SCLK_O(sclk_o), .SCLK_OE_N_O(sclk_oe_n),
        .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE_N_O(mosi_oe_n),
        .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE_N_O(miso_oe_n),
        .DEVSEL_N_I(devsel_n), .FLAG_SEL_N_O(flag_n),
        .MEM_WE_O(mem_we), .MEM_ADDR_O(mem_addr), .MEM_WDATA_O(mem_wdata),
        .KERNEL_RUN_O(run), .KERNEL_PC_O(pc), .LINK_BOOT_O(link),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp));

    sblp_far_end u_sblp_far_end (
        .sclk_w_i(sclk_w), .flag_n_i(flag_n), .mosi_w_i(mosi_w),
        .sclk_o(f_sclk), .mosi_o(f_mosi), .devsel_n_o(devsel_n),
        .miso_o(f_miso), .cmd_o(cmd));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("mismatches=%0d comparisons=%0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1)
        begin
            err_count++;
            close_out();
        end
    endtask

    // one single-word transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic boot(input logic [2:0] c);
        rst_n <= 1'b0;
        cfg   <= c;
        nw = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (16) @(posedge clk);
    endtask

    // words are watched mid-cycle so the write pulse is seen settled
    always @(negedge clk)
        if (mem_we === 1'b1)
        begin
            chk(32'(mem_addr), 32'(nw));
            chk(mem_wdata, u_sblp_far_end.word(nw));
            // the select rises with the last word's write pulse, never before it
            if (cfg == 3'h1)
                chk(32'(flag_n), (nw == BOOT_DMA_WORDS - 1) ? 32'h1 : 32'h0);
            nw++;
        end

    initial
    begin
        rst_n  = 1'b0;
        cfg    = 3'h0;
        hsel   = 1'b0;
        htrans = 2'h0;
        haddr  = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        boot(3'h0);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h000003B1);
        chk(32'({miso_oe_n, miso_o, hresp}), 32'h4);
        bus(1'b1, CTRL_OFS, 32'hFFFFFFFF);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h000003BD);
        // word length zero must not change the 32-bit packing
        bus(1'b1, CTRL_OFS, 32'h0);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, STAT_OFS, 32'h0);
        chk(32'(rd[2:0]), 32'h0);
        u_sblp_far_end.slave_send(2);
        repeat (8) @(posedge clk);
        bus(1'b0, STAT_OFS, 32'h0);
        chk(32'(rd[24:16]), 32'd382);
        chk(32'(rd[5]), 32'h1);
        chk(32'(nw), 32'h2);
        boot(3'h4);
        chk(32'(link), 32'h1);
        boot(3'h1);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h000003B3);
        for (int i = 0; i < 99500 && run !== 1'b1; i++)
            @(posedge clk);
        if (run !== 1'b1)
        begin
            err_count++;
            close_out();
        end
        repeat (2) @(posedge clk);
        chk(32'(nw), 32'd384);
        chk(32'(pc), 32'h00000123);
        chk(cmd, 32'h000000C0);
        chk(32'(flag_n), 32'h1);
        chk(32'({sclk_oe_n, mosi_oe_n, sclk_o}), 32'h7);
        bus(1'b0, RXBUF_OFS, 32'h0);
        chk(rd, u_sblp_far_end.word(383));
        close_out();
    end
endmodule // sblp_boot_port_tb
